// ===== verilog/supply_good_status.sv
// supply-good status logic of a power-path protection switch
// assumes comparator inputs are asynchronous and an external pull-up sits on the output pin
`timescale 1ns/1ps
module supply_good_status #(
    parameter logic ACTIVE_LEVEL = supply_good_pkg::ACTIVE_HIGH // 1: high-true pin
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // supply comparators, asynchronous, high when tripped; supplyPresent is high when the supply is up
    input wire logic supplyBrownoutDetect, // below brownout threshold
    input wire logic undervoltageLockout, // below undervoltage threshold
    input wire logic overvoltageLockout, // above overvoltage threshold
    input wire logic shutdownThreshold, // enable below shutdown level
    input wire logic supplyPresent, // internal supply up
    // gate drive status, asynchronous
    input wire logic gateOverdriveReached,
    // load-side events, for reverse blocking only
    input wire logic loadFault, // overcurrent, short, monitor pin or thermal fault
    // reverse blocking control pin, high or open enables blocking
    input wire logic reverseBlockControl,
    // supply-good open-drain pin
    output logic supplyValidOut, // pin output value, always low
    output logic supplyValidOe_n, // low while pulling the pin low
    // status outputs
    output logic inrushActive, // inrush sequence in progress
    output logic reverseBlockEnable // reverse blocking active
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int NUM_IN = 8; // synchronised inputs
    logic [NUM_IN-1:0] rawIn; // asynchronous inputs
    logic [NUM_IN-1:0] syncIn; // after two flops
    assign rawIn = {reverseBlockControl, loadFault, supplyPresent, gateOverdriveReached,
                    shutdownThreshold, overvoltageLockout, undervoltageLockout,
                    supplyBrownoutDetect};
    // one two-flop stage per input, only the second flop reads the first
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_sync
            level_sync u_sync (
                .clk_sys(clk_sys),
                .reset_n(reset_n),
                .levelIn(rawIn[gi]),
                .levelOut(syncIn[gi])
            );
        end
    endgenerate
    logic brownSync, uvSync, ovSync, sdSync, gateSync, presSync, faultSync, rcbSync;
    assign {rcbSync, faultSync, presSync, gateSync, sdSync, ovSync, uvSync, brownSync} = syncIn;
    // supply is valid only with supply present and every other supply comparator clear
    logic supplyOk;
    assign supplyOk = presSync && !brownSync && !uvSync && !ovSync && !sdSync;
    // ------------------------------------------------------------
    // supply-good state machine
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_OFF, ST_INRUSH, ST_GOOD} sg_state_e;
    sg_state_e state, next_state;
    logic validInt, next_validInt; // asserted level, polarity-free
    logic inrush, next_inrush;
    // next state; load faults are deliberately not an input here
    always_comb begin
        next_state = state;
        unique case (state)
            ST_OFF: begin // held deasserted until supply is valid
                if (supplyOk) begin
                    next_state = ST_INRUSH;
                end
            end
            ST_INRUSH: begin
                if (!supplyOk) begin
                    next_state = ST_OFF;
                end else if (gateSync) begin
                    next_state = ST_GOOD;
                end
            end
            ST_GOOD: begin // only supply loss leaves this state
                if (!supplyOk) begin
                    next_state = ST_OFF;
                end
            end
            default: begin // unused code, fall back to the safe deasserted state
                next_state = ST_OFF;
            end
        endcase
        next_validInt = (next_state == ST_GOOD);
        next_inrush = (next_state == ST_INRUSH);
    end
    // register state; reset lands in the pre-inrush state
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_OFF;
            validInt <= supply_good_pkg::VALID_RESET;
            inrush <= supply_good_pkg::INRUSH_RESET;
        end else begin
            state <= next_state;
            validInt <= next_validInt;
            inrush <= next_inrush;
        end
    end
    // ------------------------------------------------------------
    // pin drive and reverse blocking
    // ------------------------------------------------------------
    logic next_oe_n, next_block;
    // pin is released when its level should read high; pull-up makes the high
    // without supply nothing pulls, so the pin floats to the pull-up level
    always_comb begin
        if (!presSync) begin
            next_oe_n = 1'h1;
        end else begin
            next_oe_n = (next_validInt == ACTIVE_LEVEL);
        end
        // blocking may drop only in steady state with no fault
        next_block = !(next_state == ST_GOOD && !faultSync && !rcbSync);
    end
    // outputs straight from flops
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            supplyValidOe_n <= supply_good_pkg::OE_RESET;
            reverseBlockEnable <= supply_good_pkg::BLOCK_RESET;
        end else begin
            supplyValidOe_n <= next_oe_n;
            reverseBlockEnable <= next_block;
        end
    end
    // open-drain data is constant low, a flop to keep outputs registered
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            supplyValidOut <= supply_good_pkg::PIN_DATA;
        end else begin
            supplyValidOut <= supply_good_pkg::PIN_DATA;
        end
    end
    assign inrushActive = inrush;
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // inrush ends when the synchronised gate flag is seen during inrush
    sequence s_inrush_done;
        state == ST_INRUSH && supplyOk && gateSync;
    endsequence
    // a valid supply seen while off opens the inrush phase
    sequence s_start_inrush;
        state == ST_OFF && supplyOk;
    endsequence
    // control low and no fault, then steady state one edge later
    sequence s_block_released;
        !faultSync && !rcbSync ##1 state == ST_GOOD;
    endsequence
    // supply-good never stands without a valid supply one edge before
    goodNeedsSupply_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        validInt |-> $past(supplyOk))
        else $error("valid without supply");
    // a supply that turns bad during inrush sends the machine back to off
    inrushAbort_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        state == ST_INRUSH && !supplyOk |=> state == ST_OFF && !inrushActive)
        else $error("inrush kept on bad supply");
    // the data flop of the open-drain pin never carries a high
    pinDrive_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        supplyValidOut == 1'h0)
        else $error("pin drives high");
    // with supply present the enable follows the asserted level and polarity
    polarityPin_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        presSync ##1 presSync |-> supplyValidOe_n == (validInt == ACTIVE_LEVEL))
        else $error("pin level wrong for polarity");
    // supply-good can only rise out of the inrush state
    inrushBefore_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(validInt) |-> $past(state) == ST_INRUSH)
        else $error("skipped inrush");
    // a valid supply while off starts inrush with supply-good still low
    inrushStart_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_start_inrush |=> inrushActive && !validInt)
        else $error("inrush not started");
    // the off state never jumps straight to supply-good
    offNoGood_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        state == ST_OFF |=> !validInt)
        else $error("asserted straight from off");
    // full overdrive during inrush with a valid supply asserts on the very next edge
    assertOnGate_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_inrush_done |=> validInt ##0 state == ST_GOOD)
        else $error("late assert");
    // supply-good only rises after the gate flag was seen
    gateBeforeGood_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(validInt) |-> $past(gateSync))
        else $error("asserted without overdrive");
    // an invalid supply drops supply-good on the next edge
    dropOnInvalid_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        validInt && !supplyOk |=> !validInt)
        else $error("held while invalid");
    // with a valid supply nothing else, load events included, drops it
    faultNoEffect_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        validInt && supplyOk |=> validInt)
        else $error("dropped on load event");
    // without supply the pin is released, never pulled down
    noPullDown_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !presSync |=> supplyValidOe_n)
        else $error("pull-down without supply");
    // control low in steady state with no fault frees reverse current
    ctrlLowFrees_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_block_released |-> !reverseBlockEnable)
        else $error("blocking not released");
    // control high or open keeps blocking on
    ctrlHighBlocks_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        rcbSync |=> reverseBlockEnable)
        else $error("blocking off with control high");
    // outside steady state blocking stays on whatever the control pin says
    blockSteady_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        state != ST_GOOD |-> reverseBlockEnable)
        else $error("blocking dropped");
    // a load fault keeps blocking on
    faultBlocks_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        faultSync |=> reverseBlockEnable)
        else $error("blocking dropped on fault");
    // the first edge after reset still shows the pre-inrush reset values
    resetState_a: assert property (@(posedge clk_sys)
        $rose(reset_n) |-> state == ST_OFF && !validInt && !inrushActive && supplyValidOe_n)
        else $error("reset state wrong");
endmodule : supply_good_status

// ===== verilog/supply_good_pkg.sv
// constants shared by the supply-good status logic
// assumes a single 40 MHz system clock domain
package supply_good_pkg;
    // ------------------------------------------------------------
    // synchroniser and reset values
    // ------------------------------------------------------------
    localparam int SYNC_STAGES = 2; // flops per comparator input
    localparam logic SYNC_RESET = 1'h0; // synchroniser reset level
    localparam logic VALID_RESET = 1'h0; // supply-good deasserted at reset
    localparam logic BLOCK_RESET = 1'h1; // reverse blocking active at reset
    localparam logic ACTIVE_HIGH = 1'h1; // polarity value for active-high variant
    localparam logic OE_RESET = 1'h1; // pin released during reset
    localparam logic INRUSH_RESET = 1'h0; // no inrush in progress at reset
    localparam logic PIN_DATA = 1'h0; // open-drain data, only ever pulls low
endpackage : supply_good_pkg

// ===== verilog/level_sync.sv
// two-flop synchroniser for one asynchronous level
// assumes input comes from an analog comparator or pin
`timescale 1ns/1ps
module level_sync (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // level in and out
    input wire logic levelIn,
    output logic levelOut
);
    // ------------------------------------------------------------
    // synchroniser stages
    // ------------------------------------------------------------
    logic stageOne; // first flop, read only by the second
    // both flops reset to a constant; no logic between them
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stageOne <= supply_good_pkg::SYNC_RESET;
            levelOut <= supply_good_pkg::SYNC_RESET;
        end else begin
            stageOne <= levelIn;
            levelOut <= stageOne;
        end
    end
endmodule : level_sync

// ===== verification/supply_good_supervisor.sv
// downstream supervisor model seen from the supply-good pin
// assumes the pin is open-drain and this side owns the pull-up
`timescale 1ns/1ps
module supply_good_supervisor (
    // open-drain pin from the status logic
    input wire logic supplyValidOut,
    input wire logic supplyValidOe_n,
    // resolved wire level, read as supply-valid status
    output logic pinLevel
);
    // ----------------------------------------
    // pin resolution
    // ----------------------------------------
    // released pin is pulled up to our own rail, so no stale value survives
    assign pinLevel = supplyValidOe_n ? 1'h1 : supplyValidOut;
endmodule : supply_good_supervisor

// ===== verification/supply_good_status_bench.sv
// self-checking bench for the supply-good status logic
// assumes a 3-cycle input latency: two synchroniser flops and one state flop
`timescale 1ns/1ps
module supply_good_status_bench;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam logic ACT = supply_good_pkg::ACTIVE_HIGH; // pin polarity under test
    localparam logic ACT_LOW = ~supply_good_pkg::ACTIVE_HIGH; // second, active-low variant
    logic clk_sys, reset_n, brown, uv, ov, sd, present, gate, loadFault, ctrl;
    logic sOut, sOe_n, inrush, blockEn, pinLevel;
    logic sOutLow, sOeLow_n, inrushLow, blockLow, pinLow; // active-low variant
    logic [5:0] notes[$]; // expected pin of both variants, inrush x2, blocking x2
    int error_cnt, compares, st; // st: 0 off, 1 inrush, 2 good
    event seen;
    supply_good_status #(.ACTIVE_LEVEL(ACT)) i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .supplyBrownoutDetect(brown), .undervoltageLockout(uv), .overvoltageLockout(ov),
        .shutdownThreshold(sd), .supplyPresent(present), .gateOverdriveReached(gate),
        .loadFault(loadFault), .reverseBlockControl(ctrl), .supplyValidOut(sOut),
        .supplyValidOe_n(sOe_n), .inrushActive(inrush), .reverseBlockEnable(blockEn));
    supply_good_supervisor i_sup (.supplyValidOut(sOut), .supplyValidOe_n(sOe_n),
        .pinLevel(pinLevel));
    // same stimulus into the active-low variant so both polarities are checked
    supply_good_status #(.ACTIVE_LEVEL(ACT_LOW)) i_dutLow (.clk_sys(clk_sys), .reset_n(reset_n),
        .supplyBrownoutDetect(brown), .undervoltageLockout(uv), .overvoltageLockout(ov),
        .shutdownThreshold(sd), .supplyPresent(present), .gateOverdriveReached(gate),
        .loadFault(loadFault), .reverseBlockControl(ctrl), .supplyValidOut(sOutLow),
        .supplyValidOe_n(sOeLow_n), .inrushActive(inrushLow), .reverseBlockEnable(blockLow));
    supply_good_supervisor i_supLow (.supplyValidOut(sOutLow), .supplyValidOe_n(sOeLow_n),
        .pinLevel(pinLow));
    // ----------------------------------------
    // clock and reporting
    // ----------------------------------------
    initial begin
        clk_sys = 1'h0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task conclude;
        if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task check_status(input logic [5:0] exp, input logic [5:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value status expected %b seen %b", exp, got);
        end
    endtask : check_status
    // watcher takes the oldest note whenever a settled result appears
    initial forever begin
        @(seen);
        check_status(notes.pop_front(),
            {pinLevel, pinLow, inrush, inrushLow, blockEn, blockLow});
    end
    // ----------------------------------------
    // stimulus and reference model
    // ----------------------------------------
    // one random input set held long enough for two state moves
    task step;
        logic ok, good, blk;
        brown = ($urandom % 5) == 0;
        uv = ($urandom % 5) == 0;
        ov = ($urandom % 5) == 0; // supply may rise above the overvoltage threshold
        sd = ($urandom % 5) == 0;
        present = ($urandom % 8) != 0;
        gate = 1'($urandom % 2);
        loadFault = 1'($urandom % 2); // load events must not disturb the pin
        ctrl = 1'($urandom % 2);
        repeat (6) @(negedge clk_sys);
        ok = present & ~brown & ~uv & ~ov & ~sd;
        repeat (2) begin
            if (!ok) st = 0; // invalid supply drops to off
            else if (st == 0) st = 1; // inrush starts on valid supply
            else if (st == 1 && gate) st = 2; // full overdrive ends inrush
        end
        good = (st == 2);
        blk = !(good && !loadFault && !ctrl);
        // without supply the pin is released and the pull-up shows a high
        notes.push_back({present ? (good ~^ ACT) : 1'h1, present ? (good ~^ ACT_LOW) : 1'h1,
                         st == 1, st == 1, blk, blk});
        ->seen;
    endtask : step
    initial begin
        {brown, uv, ov, sd, present, gate, loadFault, ctrl} = 8'h0;
        reset_n = 1'h0;
        st = 0;
        void'($urandom(32'hcbdc72dc));
        repeat (3) @(negedge clk_sys);
        reset_n = 1'h1;
        for (int i = 0; i < 200; i++) begin
            if (i == 100) begin
                // mid-run reset must return to the pre-inrush state
                reset_n = 1'h0;
                @(negedge clk_sys);
                reset_n = 1'h1;
                st = 0;
            end
            step();
        end
        @(negedge clk_sys);
        conclude();
    end
endmodule : supply_good_status_bench
